// file: src/cnt_bank_pkg.sv
package cnt_bank_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [15:0] STORAGE_NEEDED_LO_OFFSET = 16'h2280;
	localparam logic [15:0] STORAGE_NEEDED_HI_OFFSET = 16'h2284;
	localparam logic [15:0] PRIMS_WRITTEN_LO_OFFSET = 16'h2288;
	localparam logic [15:0] PRIMS_WRITTEN_HI_OFFSET = 16'h228c;
	localparam logic [15:0] ELAPSED_LO_OFFSET = 16'h2358;
	localparam logic [15:0] ELAPSED_HI_OFFSET = 16'h235c;
	localparam logic [15:0] TABLE_OVERRIDE_OFFSET = 16'h2370;
	localparam logic [15:0] MATCH_RESET_OFFSET = 16'h2524;

	// ==========================================================
	// Field positions
	localparam int OVERRIDE_ENABLE_BIT = 1;
	localparam int OVERRIDE_COUNT_LSB = 2;
	localparam int MATCH_PENDING_BIT = 0;
	localparam int MATCH_FLAG_BIT = 1;
	localparam int CONTEXT_ID_LSB = 2;
	localparam int CONTEXT_ID_WIDTH = 10;
	localparam int SUBCOUNT_LSB = 20;

	// ==========================================================
	// Reset values and timing
	localparam logic [63:0] COUNT_RESET_VALUE = 64'h0;
	localparam logic [31:0] REG_RESET_VALUE = 32'h0;
	localparam logic [3:0] LEGACY_DIVIDE_LAST = 4'hf;
	// Reference clock period in picoseconds (25 ns)
	localparam int REF_PERIOD_PS = 25000;
	// Quarter-nanosecond steps per reference cycle
	localparam logic [43:0] QUARTER_NS_PER_CYCLE = 44'(REF_PERIOD_PS / 250);
	localparam int HANDSHAKE_CYCLES = 2;

	// Context-match sequencer states
	typedef enum logic [3:0] {
		MATCH_IDLE = 4'b0001,
		MATCH_COMPARE = 4'b0010,
		MATCH_RESETTING = 4'b0100,
		MATCH_DONE = 4'b1000
	} match_state_type;

endpackage : cnt_bank_pkg

// file: src/event_counter64.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// 64-bit event counter: clear by write, load on restore
module event_counter64 (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic event_in,
	input wire logic clear_in,
	input wire logic load_in,
	input wire logic [63:0] load_value_in,
	output logic [63:0] count_out
);
	import cnt_bank_pkg::*;

	logic [63:0] count_q; // Running count
	logic [63:0] count_d; // Next count

	// Clear and restore take priority over an event in the same cycle
	assign count_d = clear_in ? COUNT_RESET_VALUE :
		load_in ? load_value_in :
		event_in ? count_q + 64'h1 : count_q;

	// Count register
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			count_q <= COUNT_RESET_VALUE;
		end else begin
			count_q <= count_d;
		end
	end

	assign count_out = count_q;
endmodule : event_counter64
`default_nettype wire

// file: src/gpu_counter_register_bank.sv
// Function
// - Legacy count steps once per 16 clocks
// - Time counter runs on ungated reference clock
// - Time survives graphics reset, cleared by chip
// - Pipeline sample of time without flush
// - Constant-rate increment scaled to clock frequency
// - Any half write clears constant-rate counter
// - Upper half counts 1.024 microsecond units
// - Quarter-ns subcount bits 31:20, low zero
// - Count used only while enable bit set
// - Count each streamed vertex write message
// - Count flagged messages for storage needed
// - Write clears the stream-output counter
// - Stream counters never loaded by write, restored from context
`timescale 1ns/10ps
`default_nettype none
module gpu_counter_register_bank (
	input wire logic CLK_IN,
	input wire logic SRST_IN,
	// Graphics-only reset; the time counter ignores it
	input wire logic GFX_RST_IN,
	// Strap: 1 selects the constant-rate time layout
	input wire logic RATE_MODE_IN,
	// Register port
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic [15:0] REG_ADDR_IN,
	input wire logic [31:0] REG_WDATA_IN,
	output logic [31:0] REG_RDATA_OUT,
	// Geometry-shader stream-output messages
	input wire logic SO_WRITE_MSG_IN,
	input wire logic SO_STORAGE_FLAG_IN,
	// Context restore of stream-output counters
	input wire logic CTX_RESTORE_IN,
	input wire logic [63:0] CTX_PRIMS_WRITTEN_IN,
	input wire logic [63:0] CTX_STORAGE_NEEDED_IN,
	// Pipeline sample request and its captured time
	input wire logic TIME_SAMPLE_IN,
	output logic [63:0] TIME_SAMPLE_OUT,
	output logic TIME_SAMPLE_VALID_OUT,
	// Running context ID and render-only reset handshake
	input wire logic [9:0] RUNNING_CTX_ID_IN,
	output logic RENDER_RESET_OUT,
	input wire logic RENDER_RESET_DONE_IN,
	output logic MATCH_IRQ_OUT,
	// Translation table size in use
	output logic TABLE_OVERRIDE_EN_OUT,
	output logic [29:0] TABLE_CACHELINES_OUT
);
	import cnt_bank_pkg::*;

	// ==========================================================
	// Address decode
	// A write acts at the edge that samples REG_WR_IN high
	// Reads share the address but have no side effect on any counter
	// Full 16-bit compare, so aliases of these offsets stay unmapped
	wire wr_elapsed_lo = REG_WR_IN && (REG_ADDR_IN == ELAPSED_LO_OFFSET);
	wire wr_elapsed_hi = REG_WR_IN && (REG_ADDR_IN == ELAPSED_HI_OFFSET);
	wire wr_override = REG_WR_IN && (REG_ADDR_IN == TABLE_OVERRIDE_OFFSET);
	wire wr_match = REG_WR_IN && (REG_ADDR_IN == MATCH_RESET_OFFSET);
	// Either half of a stream counter clears the whole 64 bits
	wire wr_storage = REG_WR_IN && ((REG_ADDR_IN == STORAGE_NEEDED_LO_OFFSET) ||
		(REG_ADDR_IN == STORAGE_NEEDED_HI_OFFSET));
	wire wr_prims = REG_WR_IN && ((REG_ADDR_IN == PRIMS_WRITTEN_LO_OFFSET) ||
		(REG_ADDR_IN == PRIMS_WRITTEN_HI_OFFSET));

	// ==========================================================
	// Strap capture
	// The layout is fixed from the end of a full reset until the next one;
	// a strap change in between is ignored, so software never sees a mixed view
	logic rate_mode_q; // Latched layout select
	// Strap caught on the clock while reset is held, not by async load
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			rate_mode_q <= RATE_MODE_IN;
		end
	end

	// ==========================================================
	// Elapsed-time counter
	// CLK_IN is the ungated reference clock; nothing gates it here
	// Both layouts count at once; the strap only picks which one is read
	logic [3:0] div_q; // Legacy prescaler
	logic [63:0] legacy_q; // Legacy count
	logic [63:0] legacy_d;
	logic [43:0] quarter_q; // Constant-rate count in quarter-ns
	logic [43:0] quarter_d;
	// Prescaler end point: one legacy step per full turn of div_q
	wire div_wrap = (div_q == LEGACY_DIVIDE_LAST);
	// Trade-off: one adder with a build-time step replaces a divider per
	// reference frequency; a different clock needs a new step constant

	// A write wins over the prescaler step, so the loaded half is exact
	// Legacy writes load the value; software should only write zero
	assign legacy_d = wr_elapsed_lo ? {legacy_q[63:32], REG_WDATA_IN} :
		wr_elapsed_hi ? {REG_WDATA_IN, legacy_q[31:0]} :
		div_wrap ? legacy_q + 64'h1 : legacy_q;
	// The quarter count wraps silently at its full width
	// Increment scaled by the clock period gives a fixed real-time rate
	assign quarter_d = (wr_elapsed_lo || wr_elapsed_hi) ? 44'h0 :
		quarter_q + QUARTER_NS_PER_CYCLE;

	// Of the two resets only the full one clears time; GFX_RST_IN not used here
	// The prescaler restarts with the count, so steps fall 16 clocks apart
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			div_q <= 4'h0;
			legacy_q <= COUNT_RESET_VALUE;
			quarter_q <= 44'h0;
		end else begin
			div_q <= div_q + 4'h1;
			legacy_q <= legacy_d;
			quarter_q <= quarter_d;
		end
	end

	// Only 12 subcount bits are kept; the low 20 bits are wired to zero
	// Constant-rate view: hi = 1.024 us units, bits 31:20 subcount
	wire [63:0] rate_view = {quarter_q[43:12], quarter_q[11:0], 20'h0};
	wire [63:0] time_view = rate_mode_q ? rate_view : legacy_q;

	// Pipeline sample captured in order, no flush required
	// The captured value stands until the next request, so it may be read late
	// The valid flag is a one-cycle pulse that follows each request
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			TIME_SAMPLE_OUT <= COUNT_RESET_VALUE;
			TIME_SAMPLE_VALID_OUT <= 1'b0;
		end else begin
			TIME_SAMPLE_VALID_OUT <= TIME_SAMPLE_IN;
			if (TIME_SAMPLE_IN) begin
				TIME_SAMPLE_OUT <= time_view;
			end
		end
	end

	// ==========================================================
	// Stream-output counters
	// Two instances of one counter module; their event, clear and load-value inputs differ
	wire [63:0] prims_count;
	wire [63:0] storage_count;
	wire stream_clear_prims = wr_prims || GFX_RST_IN;
	wire stream_clear_storage = wr_storage || GFX_RST_IN;
	// Graphics reset clears these counters, unlike the time counter
	// A clear in the restore cycle wins inside the counter

	// Every streamed write message counts
	event_counter64 prims_counter (
		.clk_in(CLK_IN),
		.srst_in(SRST_IN),
		.event_in(SO_WRITE_MSG_IN),
		.clear_in(stream_clear_prims),
		.load_in(CTX_RESTORE_IN),
		.load_value_in(CTX_PRIMS_WRITTEN_IN),
		.count_out(prims_count)
	);

	// Only messages with the storage flag count
	event_counter64 storage_counter (
		.clk_in(CLK_IN),
		.srst_in(SRST_IN),
		.event_in(SO_WRITE_MSG_IN && SO_STORAGE_FLAG_IN),
		.clear_in(stream_clear_storage),
		.load_in(CTX_RESTORE_IN),
		.load_value_in(CTX_STORAGE_NEEDED_IN),
		.count_out(storage_count)
	);

	// ==========================================================
	// Translation table override
	// Bit 0 is stored as zero so that it always reads back zero
	logic [31:0] override_q; // Stored register, bit 0 reserved
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			override_q <= REG_RESET_VALUE;
		end else if (wr_override) begin
			override_q <= {REG_WDATA_IN[31:1], 1'b0};
		end
	end

	// Count passed out only while enabled, else zero
	// Registered outputs: the table logic sees a write two clocks later
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			TABLE_OVERRIDE_EN_OUT <= 1'b0;
			TABLE_CACHELINES_OUT <= 30'h0;
		end else begin
			TABLE_OVERRIDE_EN_OUT <= override_q[OVERRIDE_ENABLE_BIT];
			TABLE_CACHELINES_OUT <= override_q[OVERRIDE_ENABLE_BIT] ?
				override_q[31:OVERRIDE_COUNT_LSB] : 30'h0;
		end
	end

	// ==========================================================
	// Context-match render reset
	match_state_type state_q; // Sequencer state
	match_state_type state_d;
	logic [9:0] match_id_q; // Written context ID
	logic pending_q; // Comparison outstanding
	logic match_q; // Result of latest comparison
	// The ID is held from the write and compared with the running context
	wire id_equal = (match_id_q == RUNNING_CTX_ID_IN);
	wire start_cmp = wr_match && REG_WDATA_IN[MATCH_PENDING_BIT];
	// A write with pending clear starts nothing

	// Next-state selection
	always_comb begin
		state_d = state_q;
		case (state_q)
			MATCH_IDLE: begin
				// Only the idle state looks at a request; busy writes are dropped
				if (start_cmp) begin
					state_d = MATCH_COMPARE;
				end
			end
			MATCH_COMPARE: begin
				// Match starts reset, mismatch finishes at once
				state_d = id_equal ? MATCH_RESETTING : MATCH_DONE;
			end
			MATCH_RESETTING: begin
				// Wait for the render engine to finish its reset
				if (RENDER_RESET_DONE_IN) begin
					state_d = MATCH_DONE;
				end
			end
			MATCH_DONE: begin
				// One cycle to drop pending and raise the interrupt
				state_d = MATCH_IDLE;
			end
			default: begin
				// An illegal code falls back to idle
				state_d = MATCH_IDLE;
			end
		endcase
	end

	// Sequencer, flags and outputs
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			state_q <= MATCH_IDLE;
			match_id_q <= 10'h0;
			pending_q <= 1'b0;
			match_q <= 1'b0;
			RENDER_RESET_OUT <= 1'b0;
			MATCH_IRQ_OUT <= 1'b0;
		end else begin
			state_q <= state_d;
			// The interrupt is a one-cycle pulse, low unless set below
			MATCH_IRQ_OUT <= 1'b0;
			// Capture the request and mark it outstanding
			if (state_q == MATCH_IDLE && start_cmp) begin
				match_id_q <= REG_WDATA_IN[CONTEXT_ID_LSB +: CONTEXT_ID_WIDTH];
				pending_q <= 1'b1;
			end
			if (state_q == MATCH_COMPARE) begin
				// One comparison; its result stands until the next request
				match_q <= id_equal;
				RENDER_RESET_OUT <= id_equal;
			end
			// The render engine's done ends the reset level
			if (state_q == MATCH_RESETTING && RENDER_RESET_DONE_IN) begin
				RENDER_RESET_OUT <= 1'b0;
			end
			if (state_q == MATCH_DONE) begin
				// Pending cleared last so match is stable when it reads zero
				pending_q <= 1'b0;
				MATCH_IRQ_OUT <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Read data
	// Reads have no side effect, so a stray read is harmless
	// Halves of a 64-bit count are read apart; a carry between them can tear
	logic [31:0] rdata_d;
	always_comb begin
		case (REG_ADDR_IN)
			STORAGE_NEEDED_LO_OFFSET: rdata_d = storage_count[31:0];
			STORAGE_NEEDED_HI_OFFSET: rdata_d = storage_count[63:32];
			PRIMS_WRITTEN_LO_OFFSET: rdata_d = prims_count[31:0];
			PRIMS_WRITTEN_HI_OFFSET: rdata_d = prims_count[63:32];
			ELAPSED_LO_OFFSET: rdata_d = time_view[31:0];
			ELAPSED_HI_OFFSET: rdata_d = time_view[63:32];
			TABLE_OVERRIDE_OFFSET: rdata_d = override_q;
			MATCH_RESET_OFFSET: rdata_d = {20'h0, match_id_q, match_q, pending_q};
			// Unmapped offsets read as zero
			default: rdata_d = 32'h0;
		endcase
	end

	// Read data registered, answers the cycle after the read
	// Only a read updates the output, so it stands between reads
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			REG_RDATA_OUT <= REG_RESET_VALUE;
		end else if (REG_RD_IN) begin
			REG_RDATA_OUT <= rdata_d;
		end
	end
endmodule : gpu_counter_register_bank
`default_nettype wire

// file: testbench/bank_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port-level checks of the counter bank
module bank_chk
	import cnt_bank_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic SRST_IN,
	input wire logic REG_WR_IN,
	input wire logic [15:0] REG_ADDR_IN,
	input wire logic [31:0] REG_WDATA_IN,
	input wire logic TIME_SAMPLE_IN,
	input wire logic TIME_SAMPLE_VALID_OUT,
	input wire logic [9:0] RUNNING_CTX_ID_IN,
	input wire logic RENDER_RESET_OUT,
	input wire logic RENDER_RESET_DONE_IN,
	input wire logic MATCH_IRQ_OUT,
	input wire logic TABLE_OVERRIDE_EN_OUT,
	input wire logic [29:0] TABLE_CACHELINES_OUT
);
	default clocking @(posedge CLK_IN);
	endclocking
	default disable iff (SRST_IN);
	// Match request with render reset and interrupt low; writes in the reset state are ignored, so they are left out
	wire logic cm_req = REG_WR_IN && REG_ADDR_IN == MATCH_RESET_OFFSET && REG_WDATA_IN[0]
		&& !RENDER_RESET_OUT && !MATCH_IRQ_OUT;
	// Written ID names the running context
	wire logic cm_hit = REG_WDATA_IN[11:2] == RUNNING_CTX_ID_IN;
	chk_sample_valid: assert property (TIME_SAMPLE_IN |=> TIME_SAMPLE_VALID_OUT)
		else $error("sample not answered");
	chk_sample_quiet: assert property (!TIME_SAMPLE_IN |=> !TIME_SAMPLE_VALID_OUT)
		else $error("stray sample valid");
	chk_table_gate: assert property (!TABLE_OVERRIDE_EN_OUT |-> TABLE_CACHELINES_OUT == 30'h0)
		else $error("count used while disabled");
	chk_table_load: assert property (REG_WR_IN && REG_ADDR_IN == TABLE_OVERRIDE_OFFSET |->
		##2 TABLE_OVERRIDE_EN_OUT == $past(REG_WDATA_IN[1], 2)) else $error("override not taken");
	chk_match_start: assert property (cm_req && cm_hit |-> ##[1:4] RENDER_RESET_OUT)
		else $error("no render reset");
	chk_mismatch_skip: assert property (cm_req && !cm_hit |=> !RENDER_RESET_OUT [*4])
		else $error("reset on mismatch");
	chk_mismatch_irq: assert property (cm_req && !cm_hit |-> ##[2:6] MATCH_IRQ_OUT)
		else $error("no mismatch interrupt");
	chk_done_irq: assert property (RENDER_RESET_OUT && RENDER_RESET_DONE_IN |->
		##[1:5] MATCH_IRQ_OUT) else $error("no match interrupt");
	cov_hit: cover property (cm_req && cm_hit);
	cov_miss: cover property (cm_req && !cm_hit);
	cov_sample: cover property (TIME_SAMPLE_VALID_OUT);
endmodule : bank_chk
bind gpu_counter_register_bank bank_chk chk_u (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN),
	.REG_WR_IN(REG_WR_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
	.TIME_SAMPLE_IN(TIME_SAMPLE_IN), .TIME_SAMPLE_VALID_OUT(TIME_SAMPLE_VALID_OUT),
	.RUNNING_CTX_ID_IN(RUNNING_CTX_ID_IN), .RENDER_RESET_OUT(RENDER_RESET_OUT),
	.RENDER_RESET_DONE_IN(RENDER_RESET_DONE_IN), .MATCH_IRQ_OUT(MATCH_IRQ_OUT),
	.TABLE_OVERRIDE_EN_OUT(TABLE_OVERRIDE_EN_OUT), .TABLE_CACHELINES_OUT(TABLE_CACHELINES_OUT));
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import cnt_bank_pkg::*;
	// ==========================================================
	// Stimulus and design
	logic clk = 1'b0, srst = 1'b1, gfx = 1'b0, rate = 1'b0, wr = 1'b0, rd = 1'b0;
	logic so = 1'b0, sof = 1'b0, smp = 1'b0, ld = 1'b0, fin = 1'b0;
	logic [15:0] addr = 16'h0;
	logic [31:0] wd = 32'h0;
	logic [63:0] cpw = 64'h0, csn = 64'h0;
	logic [9:0] cid = 10'h2a5;
	wire logic [31:0] rdat;
	wire logic [63:0] ts;
	wire logic tsv, rr, irq, ten;
	wire logic [29:0] tcl;
	int errors = 0, n_compared = 0, seed = 32'h4e90;
	always #12.5 clk = ~clk;
	gpu_counter_register_bank dut_u (.CLK_IN(clk), .SRST_IN(srst), .GFX_RST_IN(gfx),
		.RATE_MODE_IN(rate), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr),
		.REG_WDATA_IN(wd), .REG_RDATA_OUT(rdat), .SO_WRITE_MSG_IN(so), .SO_STORAGE_FLAG_IN(sof),
		.CTX_RESTORE_IN(ld), .CTX_PRIMS_WRITTEN_IN(cpw), .CTX_STORAGE_NEEDED_IN(csn),
		.TIME_SAMPLE_IN(smp), .TIME_SAMPLE_OUT(ts), .TIME_SAMPLE_VALID_OUT(tsv),
		.RUNNING_CTX_ID_IN(cid), .RENDER_RESET_OUT(rr), .RENDER_RESET_DONE_IN(fin),
		.MATCH_IRQ_OUT(irq), .TABLE_OVERRIDE_EN_OUT(ten), .TABLE_CACHELINES_OUT(tcl));
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic end_of_test;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	// Write, then one idle edge so the strobe never changes twice in a step
	task automatic wreg(input logic [15:0] a, input logic [31:0] d);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wreg
	// Read data is looked at mid-cycle, well after it settled
	task automatic rreg(input logic [15:0] a, output logic [31:0] d);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdat;
		@(posedge clk);
	endtask : rreg
	task automatic rd64(input logic [15:0] a, output logic [63:0] v);
		rreg(a, v[31:0]);
		rreg(a + 16'h4, v[63:32]);
	endtask : rd64
	task automatic samp(output logic [63:0] t);
		smp <= 1'b1;
		@(posedge clk);
		smp <= 1'b0;
		@(negedge clk);
		chk(tsv, 1'b1);
		t = ts;
		@(posedge clk);
	endtask : samp
	// Bounded wait for the interrupt (pick=1) or the render reset
	task automatic wait_hi(input logic pick);
		int i;
		for (i = 0; i < 20 && (pick ? irq : rr) !== 1'b1; i++)
			@(negedge clk);
		if (i == 20) begin
			errors++;
			$display("unexpected at %0t: no answer", $time);
			end_of_test();
		end
		@(posedge clk);
	endtask : wait_hi
	// ==========================================================
	// Scenarios
	initial begin
		logic [63:0] t0, t1, ep, es;
		logic [31:0] d;
		int i;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		// Unmapped write is dropped; registers start at zero
		wreg(16'h2000, 32'hffff_ffff);
		rreg(16'h2000, d);
		chk(d, 32'h0);
		rreg(ELAPSED_HI_OFFSET, d);
		chk(d, 32'h0);
		// Legacy count: three steps in 48 clocks across a graphics reset
		samp(t0);
		gfx <= 1'b1;
		@(posedge clk);
		gfx <= 1'b0;
		repeat (45) @(posedge clk);
		samp(t1);
		chk(t1 - t0, 64'h3);
		// Software only ever loads zero; the count restarts from it
		wreg(ELAPSED_LO_OFFSET, 32'h0);
		rreg(ELAPSED_LO_OFFSET, d);
		chk(d[31:1], 31'h0);
		$display("test legacy done");
		// Random messages; the flag only counts with a message
		ep = 64'h0;
		es = 64'h0;
		repeat (200) begin
			so <= 1'($random(seed));
			sof <= 1'($random(seed));
			@(posedge clk);
			ep += 64'(so);
			es += 64'(so & sof);
		end
		so <= 1'b0;
		sof <= 1'b0;
		rd64(PRIMS_WRITTEN_LO_OFFSET, t0);
		chk(t0, ep);
		rd64(STORAGE_NEEDED_LO_OFFSET, t0);
		chk(t0, es);
		wreg(PRIMS_WRITTEN_HI_OFFSET, $random(seed));
		wreg(STORAGE_NEEDED_LO_OFFSET, $random(seed));
		rd64(PRIMS_WRITTEN_LO_OFFSET, t0);
		rd64(STORAGE_NEEDED_LO_OFFSET, t1);
		chk(t0 | t1, 64'h0);
		cpw <= {$random(seed), $random(seed)};
		csn <= {$random(seed), $random(seed)};
		ld <= 1'b1;
		@(posedge clk);
		ld <= 1'b0;
		rd64(PRIMS_WRITTEN_LO_OFFSET, t0);
		chk(t0, cpw);
		rd64(STORAGE_NEEDED_LO_OFFSET, t0);
		chk(t0, csn);
		// A graphics reset clears the stream counters
		gfx <= 1'b1;
		@(posedge clk);
		gfx <= 1'b0;
		rd64(PRIMS_WRITTEN_LO_OFFSET, t0);
		rd64(STORAGE_NEEDED_LO_OFFSET, t1);
		chk(t0 | t1, 64'h0);
		$display("test stream done");
		// Override with the enable bit both ways
		for (i = 0; i < 4; i++) begin
			d = $random(seed);
			d[1] = i[0];
			wreg(TABLE_OVERRIDE_OFFSET, d);
			rreg(TABLE_OVERRIDE_OFFSET, t0[31:0]);
			chk(t0[31:0], d & 32'hffff_fffe);
			// Outputs settle two edges after the write and are looked at later
			chk(tcl, d[1] ? d[31:2] : 30'h0);
			chk(ten, d[1]);
		end
		$display("test override done");
		// Matching ID resets the renderer; a wrong ID only interrupts
		for (i = 0; i < 2; i++) begin
			wreg(MATCH_RESET_OFFSET, {20'h0, cid ^ 10'(i), 2'b01});
			if (i == 0) begin
				wait_hi(1'b0);
				fin <= 1'b1;
				@(posedge clk);
				fin <= 1'b0;
			end
			wait_hi(1'b1);
			rreg(MATCH_RESET_OFFSET, d);
			// Match is read only after the interrupt, once pending is zero
			chk(d[1:0], {i == 0, 1'b0});
		end
		$display("test match done");
		// Constant rate: fresh reset with the strap set, then clear by a write
		srst <= 1'b1;
		rate <= 1'b1;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		repeat (100) @(posedge clk);
		wreg(ELAPSED_HI_OFFSET, $random(seed));
		samp(t0);
		chk(t0[63:32], 32'h0);
		chk(t0[19:0], 20'h0);
		repeat (46) @(posedge clk);
		samp(t1);
		chk(t1 - t0, (64'(QUARTER_NS_PER_CYCLE) * 64'd48) << 20);
		$display("test rate done");
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
